// ### design/ndr_pkg.sv
// Shared constants and carrier types for the nonvolatile-memory DAC refresh sequencer
package ndr_pkg;
   // ----------------------------------------
   // Converter and channel map
   // ----------------------------------------
   localparam int DAC_BITS = 16;
   localparam int CHAN_BITS = 6;
   localparam int NUM_VOLT = 16;
   localparam int NUM_CURR = 16;
   localparam logic [CHAN_BITS-1:0] VO_LAST_CHAN = 6'h11;
   localparam logic [CHAN_BITS-1:0] VI_LAST_CHAN = 6'h23;
   localparam logic [CHAN_BITS-1:0] VO_CAL_VOFS = 6'h10;
   localparam logic [CHAN_BITS-1:0] VO_CAL_VGAIN = 6'h11;
   localparam logic [CHAN_BITS-1:0] VI_CAL_VOFS = 6'h20;
   localparam logic [CHAN_BITS-1:0] VI_CAL_IOFS = 6'h21;
   localparam logic [CHAN_BITS-1:0] VI_CAL_VGAIN = 6'h22;
   localparam logic [CHAN_BITS-1:0] VI_CAL_IGAIN = 6'h23;
   localparam int NUM_SLOTS = 36;
   // ----------------------------------------
   // Board window on the host bus
   // ----------------------------------------
   localparam logic [15:0] HOST_BASE = 16'h0000;
   localparam logic [15:0] HOST_MASK = 16'hffc0;
   // ----------------------------------------
   // Slot timing
   // ----------------------------------------
   localparam int SETTLE_NS = 2000;
   localparam int CLK_NS = 5;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRACK_NS = 1000;
   localparam int TRACK_CYC = (TRACK_NS + CLK_NS - 1) / CLK_NS;
   localparam int CORR_BITS = 8;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed
   {
      logic req;
      logic wr;
      logic [15:0] addr;
      logic [DAC_BITS-1:0] wdata;
   } ndr_host_s;
   typedef struct packed
   {
      logic ack;
      logic hit;
      logic [DAC_BITS-1:0] rdata;
   } ndr_resp_s;
   typedef struct packed
   {
      logic [DAC_BITS-1:0] code;
      logic load;
      logic [CHAN_BITS-1:0] sel;
      logic track;
   } ndr_dac_s;
endpackage

// ### design/ndr_sequencer.sv
// Refresh sequencer that drives a shared DAC from channel codes held in nonvolatile memory
`timescale 1ns/100ps
module ndr_sequencer
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Variant strap: high selects the current-capable build
   input wire logic has_current,
   // Calibration write guard
   input wire logic calibration_write_unlock,
   // Save request, one-cycle pulse
   input wire logic save_req,
   output logic save_busy,
   // Host access
   input wire ndr_pkg::ndr_host_s host,
   output ndr_pkg::ndr_resp_s resp,
   // Reference comparators on calibration outputs: high means output too high
   input wire logic cal_cmp_high,
   // Converter and demultiplexer side
   output ndr_pkg::ndr_dac_s dac,
   output logic [ndr_pkg::CORR_BITS-1:0] dac_offset_trim,
   output logic [ndr_pkg::CORR_BITS-1:0] dac_gain_trim
);
   import ndr_pkg::*;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Live codes and the nonvolatile image; neither is preset, so both start unknown until written
   logic [DAC_BITS-1:0] live_mem [NUM_SLOTS];
   logic [DAC_BITS-1:0] nv_mem [NUM_SLOTS];

   typedef enum logic [1:0]
   {
      ST_BOOT = 2'b00,
      ST_LOAD = 2'b01,
      ST_TRACK = 2'b10,
      ST_HOLD = 2'b11
   } ndr_state_e;

   ndr_state_e st_r, st_nxt;
   logic [CHAN_BITS-1:0] slot_r, slot_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [CHAN_BITS-1:0] save_idx_r, save_idx_nxt;
   logic save_busy_r, save_busy_nxt;
   logic [CORR_BITS-1:0] ofs_r, ofs_nxt, gain_r, gain_nxt;
   ndr_dac_s dac_r, dac_nxt;
   ndr_resp_s resp_r, resp_nxt;
   logic [CHAN_BITS-1:0] hidx;
   logic hit, cal_hit, wr_ok;

   // Last slot of the scan depends on the variant
   function automatic logic [CHAN_BITS-1:0] last_slot(input logic cur);
      last_slot = cur ? VI_LAST_CHAN : VO_LAST_CHAN;
   endfunction

   // Calibration channel test per variant
   function automatic logic is_cal(input logic cur, input logic [CHAN_BITS-1:0] ch);
      is_cal = cur ? (ch >= VI_CAL_VOFS && ch <= VI_CAL_IGAIN)
                   : (ch == VO_CAL_VOFS || ch == VO_CAL_VGAIN);
   endfunction

   // ----------------------------------------
   // Host decode
   // ----------------------------------------
   always_comb
   begin
      hidx = host.addr[CHAN_BITS-1:0];
      // Every request is acked; only the board window and mapped channels hit
      hit = host.req && ((host.addr & HOST_MASK) == HOST_BASE)
            && (hidx <= last_slot(has_current));
      cal_hit = is_cal(has_current, hidx);
      wr_ok = hit && host.wr && (!cal_hit || calibration_write_unlock);
      resp_nxt.ack = host.req;
      resp_nxt.hit = hit;
      resp_nxt.rdata = hit ? live_mem[hidx] : '0;
   end

   // ----------------------------------------
   // Scan sequencer and trims
   // ----------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      slot_nxt = slot_r;
      cnt_nxt = cnt_r;
      ofs_nxt = ofs_r;
      gain_nxt = gain_r;
      dac_nxt = dac_r;
      dac_nxt.load = 1'b0;
      save_idx_nxt = save_idx_r;
      save_busy_nxt = save_busy_r;
      case (st_r)
         ST_BOOT:
         begin
            // Start scanning from the first channel after reset
            slot_nxt = '0;
            st_nxt = ST_LOAD;
         end
         ST_LOAD:
         begin
            // Present the stored code and steer the demux to it
            dac_nxt.code = live_mem[slot_r];
            dac_nxt.sel = slot_r;
            dac_nxt.load = 1'b1;
            dac_nxt.track = 1'b0;
            cnt_nxt = 16'(SETTLE_CYC);
            st_nxt = ST_TRACK;
         end
         ST_TRACK:
         begin
            // Wait for the converter to settle, then track for a fixed span
            if (cnt_r != '0)
               cnt_nxt = cnt_r - 16'h0001;
            else if (!dac_r.track)
            begin
               dac_nxt.track = 1'b1;
               cnt_nxt = 16'(TRACK_CYC);
            end
            else
            begin
               dac_nxt.track = 1'b0;
               st_nxt = ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            // Calibration slots nudge the trims by the comparator result
            if (is_cal(has_current, slot_r))
            begin
               // Offset slots are named outright; the gain slot 34 is even, so parity cannot decide
               if (slot_r == VO_CAL_VOFS || slot_r == VI_CAL_VOFS || slot_r == VI_CAL_IOFS)
                  ofs_nxt = cal_cmp_high ? ofs_r + 8'h01 : ofs_r - 8'h01;
               else
                  gain_nxt = cal_cmp_high ? gain_r + 8'h01 : gain_r - 8'h01;
            end
            slot_nxt = (slot_r == last_slot(has_current)) ? '0 : slot_r + 6'h01;
            st_nxt = ST_LOAD;
         end
         default:
            st_nxt = ST_BOOT;
      endcase
      // Save walks all slots, one per cycle
      if (save_busy_r)
      begin
         if (save_idx_r == 6'(NUM_SLOTS - 1))
            save_busy_nxt = 1'b0;
         save_idx_nxt = save_idx_r + 6'h01;
      end
      else if (save_req)
      begin
         save_busy_nxt = 1'b1;
         save_idx_nxt = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         st_r <= ST_BOOT;
         slot_r <= '0;
         cnt_r <= '0;
         ofs_r <= '0;
         gain_r <= '0;
         dac_r <= '0;
         resp_r <= '0;
         save_idx_r <= '0;
         save_busy_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         slot_r <= slot_nxt;
         cnt_r <= cnt_nxt;
         ofs_r <= ofs_nxt;
         gain_r <= gain_nxt;
         dac_r <= dac_nxt;
         resp_r <= resp_nxt;
         save_idx_r <= save_idx_nxt;
         save_busy_r <= save_busy_nxt;
      end
   end

   // ----------------------------------------
   // Memory arrays; nonvolatile image survives reset, live copy reloads from it
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
         if (!resetn)
            live_mem[i] <= nv_mem[i];
         else if (wr_ok && hidx == 6'(i))
            live_mem[i] <= host.wdata;
      end
      if (save_busy_r)
         nv_mem[save_idx_r] <= live_mem[save_idx_r];
   end

   assign dac = dac_r;
   assign resp = resp_r;
   assign save_busy = save_busy_r;
   assign dac_offset_trim = ofs_r;
   assign dac_gain_trim = gain_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence load_seen;
      dac.load;
   endsequence

   wrap_order_a: assert property (@(posedge mclk) disable iff (!resetn)
      st_r == ST_HOLD |=> slot_r == (($past(slot_r) == last_slot(has_current)) ? 6'h00
                                      : $past(slot_r) + 6'h01))
      else $error("slot order broken");
   track_sel_a: assert property (@(posedge mclk) disable iff (!resetn)
      dac.track |-> dac.sel == slot_r && st_r == ST_TRACK)
      else $error("tracking wrong channel");
   sel_load_a: assert property (@(posedge mclk) disable iff (!resetn)
      load_seen |-> dac.sel == slot_r)
      else $error("demux not on loaded channel");
   code_load_a: assert property (@(posedge mclk) disable iff (!resetn)
      load_seen |-> dac.code == $past(live_mem[slot_r]))
      else $error("wrong code loaded");
   slot_range_a: assert property (@(posedge mclk) disable iff (!resetn)
      slot_r <= last_slot(has_current))
      else $error("slot past last channel");
   cal_guard_a: assert property (@(posedge mclk) disable iff (!resetn)
      host.req && host.wr && cal_hit && !calibration_write_unlock
      |=> live_mem[$past(hidx)] == $past(live_mem[hidx]))
      else $error("locked calibration write took");
   window_a: assert property (@(posedge mclk) disable iff (!resetn)
      host.req && ((host.addr & HOST_MASK) != HOST_BASE) |=> resp.ack && !resp.hit)
      else $error("outside window answered");
   save_len_a: assert property (@(posedge mclk) disable iff (!resetn)
      save_req && !save_busy |=> save_busy ##36 !save_busy)
      else $error("save walk length wrong");
   cal_scan_a: assert property (@(posedge mclk) disable iff (!resetn)
      st_r == ST_HOLD && slot_r == VI_CAL_IGAIN && has_current |=> slot_r == 6'h00)
      else $error("calibration not in scan");
endmodule

// ### verification/ndr_chan_model.sv
// Behavioural model of the track-and-hold channels behind the shared converter
`timescale 1ns/100ps
module ndr_chan_model
import ndr_pkg::*;
#(
   // Comparator threshold for the calibration stages
   parameter logic [15:0] REF = 16'h8000
)
(
   // Clock
   input wire logic mclk,
   // Converter and demultiplexer
   input wire ndr_pkg::ndr_dac_s dac,
   // Reference comparator
   output logic cal_cmp_high
);
   // Held level of every stage, cleared at start; tracking an unwritten code still loads unknowns the comparator sees
   logic [15:0] held [0:63];
   initial
   begin
      for (int i = 0; i < 64; i++)
         held[i] = 16'h0000;
   end
   // ----------------------------------------
   // Track gate: only the selected stage follows the code
   // ----------------------------------------
   always @(posedge mclk)
      if (dac.track === 1'b1)
         held[dac.sel] <= dac.code;
   // Comparator looks at whichever stage is routed now
   assign cal_cmp_high = held[dac.sel] > REF;
endmodule

// ### verification/tb_top.sv
// Self-checking testbench for the refresh sequencer
`timescale 1ns/100ps
module tb_top;
import ndr_pkg::*;
   localparam int DLY = 1;
   localparam int LIMIT = 98000;
   logic mclk, resetn, has_current, calibration_write_unlock, save_req, save_busy, cal_cmp_high;
   ndr_host_s host;
   ndr_resp_s resp;
   ndr_dac_s dac;
   logic [7:0] dac_offset_trim, dac_gain_trim;
   int bad_count, cmp_count, cyc;
   logic [15:0] q;
   logic h;
   ndr_sequencer u_dut (.mclk(mclk), .resetn(resetn), .has_current(has_current),
      .calibration_write_unlock(calibration_write_unlock), .save_req(save_req),
      .save_busy(save_busy), .host(host), .resp(resp), .cal_cmp_high(cal_cmp_high),
      .dac(dac), .dac_offset_trim(dac_offset_trim), .dac_gain_trim(dac_gain_trim));
   ndr_chan_model u_part (.mclk(mclk), .dac(dac), .cal_cmp_high(cal_cmp_high));
   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   always #2.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         bad_count++;
         close_out;
      end
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Calibration codes sit above the threshold, except odd current-build ones below it
   function automatic logic [15:0] expv(input int i, input int last);
      if (i < last - (last > 17 ? 3 : 1))
         return 16'h1000 + 16'(i);
      return (last > 17 && i % 2 == 1) ? 16'h4000 + 16'(i) : 16'hc000 + 16'(i);
   endfunction
   // Request stays up between back-to-back accesses; host_idle drops it
   task automatic host_io(input logic w, input logic [15:0] a, input logic [15:0] d);
      host = '{1'b1, w, a, d};
      @(posedge mclk);
      #DLY;
      chk(16'(resp.ack), 16'h1, "ack");
      q = resp.rdata;
      h = resp.hit;
   endtask
   task automatic host_idle;
      host.req = 1'b0;
      @(posedge mclk);
      #DLY;
   endtask
   task automatic wait_load;
      int n;
      for (n = 0; n < 1000 && dac.load !== 1'b1; n++)
      begin
         @(posedge mclk);
         #DLY;
      end
      chk(16'(n < 1000), 16'h1, "load seen");
   endtask
   task automatic next_load;
      @(posedge mclk);
      #DLY;
      wait_load;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Fill every slot, then probe the lock, the window and the slot limit
   task automatic t_host(input int last);
      calibration_write_unlock = 1'b1;
      for (int i = 0; i <= last; i++)
         host_io(1'b1, 16'(i), expv(i, last));
      host_idle;
      calibration_write_unlock = 1'b0;
      host_io(1'b1, 16'(last), 16'h0000);
      chk(16'(h), 16'h1, "locked cal hit");
      for (int i = 0; i <= last; i++)
      begin
         host_io(1'b0, 16'(i), 16'h0000);
         chk(q, expv(i, last), "readback");
         chk(16'(h), 16'h1, "hit");
      end
      host_io(1'b0, 16'(last + 1), 16'h0000);
      chk(16'(h), 16'h0, "past last slot");
      host_io(1'b0, 16'h0041, 16'h0000);
      chk(16'(h), 16'h0, "outside window");
      host_idle;
      $display("test host done");
   endtask
   // Follow whole passes of the scan; each pass moves the trims by a fixed net step
   task automatic t_scan(input int last, input int passes);
      logic [7:0] o0, g0;
      int st;
      // Current build: one slot of each trim climbs and one falls, so the net step is zero
      st = (last > 17) ? 0 : 1;
      for (int k = 0; k < 40 && dac.sel !== 6'h00; k++)
         next_load;
      for (int p = 1; p <= passes; p++)
      begin
         o0 = dac_offset_trim;
         g0 = dac_gain_trim;
         for (int i = 0; i <= last; i++)
         begin
            if (i > 0)
               next_load;
            chk(16'(dac.sel), 16'(i), "slot order");
            chk(dac.code, expv(i, last), "slot code");
         end
         next_load;
         chk(16'(dac.sel), 16'h0000, "wrap");
         for (int i = 0; i <= last; i++)
            chk(u_part.held[i], expv(i, last), "held");
         chk(16'(dac_offset_trim), 16'(o0 + 8'(st)), "offset trim");
         chk(16'(dac_gain_trim), 16'(g0 + 8'(st)), "gain trim");
      end
      $display("test scan done");
   endtask
   // Save, then reset into the wider build and read the restored image
   task automatic t_save;
      int n;
      save_req = 1'b1;
      @(posedge mclk);
      #DLY;
      save_req = 1'b0;
      for (n = 0; n < 100 && save_busy === 1'b1; n++)
      begin
         @(posedge mclk);
         #DLY;
      end
      chk(16'(n), 16'd36, "save length");
      resetn = 1'b0;
      has_current = 1'b1;
      repeat (6) @(posedge mclk);
      #DLY;
      resetn = 1'b1;
      host_io(1'b0, 16'h0005, 16'h0000);
      chk(q, 16'h1005, "restored");
      host_io(1'b0, 16'h0010, 16'h0000);
      chk(q, 16'hc010, "restored cal");
      host_idle;
      $display("test save done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      mclk = 1'b0;
      resetn = 1'b0;
      has_current = 1'b0;
      calibration_write_unlock = 1'b0;
      save_req = 1'b0;
      host = '0;
      repeat (6) @(posedge mclk);
      #DLY;
      resetn = 1'b1;
      t_host(17);
      t_scan(17, 2);
      t_save;
      t_host(35);
      t_scan(35, 1);
      close_out;
   end
endmodule
